// file: test/dac_link_props.sv
// link-level assertions for the serial frame link
`timescale 1ns/1ps
module dac_link_props (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // link signals
    input wire logic sclk,
    input wire logic sync_n,
    input wire logic serial_data_in,
    input wire logic serial_data_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // ****************************************************************
    // frame bookkeeping
    // ****************************************************************
    logic [4:0] fall_cnt_r;

    // falling sclk edges within a frame; idle sync clears it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fall_cnt_r <= 5'h00;
        end else if (sync_n) begin
            fall_cnt_r <= 5'h00;
        end else if ($fell(sclk)) begin
            fall_cnt_r <= fall_cnt_r + 5'h01;
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_frame_length: assert property ($rose(sync_n) |-> fall_cnt_r == 5'h18)
        else $error("frame did not carry 24 clock falls");
    a_data_stable: assert property ($fell(sclk) && !sync_n |->
        $stable(serial_data_in))
        else $error("serial data moved at the sampling edge");
    a_zero_bit: assert property ($fell(sclk) && !sync_n &&
        fall_cnt_r == 5'h01 |-> !serial_data_in)
        else $error("reserved frame bit sent as one");
    a_sclk_idle: assert property (sync_n |-> sclk)
        else $error("serial clock moved outside a frame");
    a_half_period: assert property ($fell(sclk) |-> !sclk [*4] ##1 sclk)
        else $error("serial clock low phase not four cycles");
    a_frame_start: assert property ($fell(sync_n) |-> sclk [*4] ##1 !sclk)
        else $error("first clock fall not four cycles after sync");
    a_frame_close: assert property ($rose(sync_n) |->
        $past(sclk, 4) && !$past(sclk, 5))
        else $error("sync released at the wrong time");
    a_idle_gap: assert property ($rose(sync_n) |-> sync_n [*4])
        else $error("sync idle gap shorter than four cycles");

    // main scenarios
    c_frame_end: cover property ($rose(sync_n));
    c_full_count: cover property (fall_cnt_r == 5'h18);
    c_readback: cover property (!sync_n && serial_data_out);
endmodule : dac_link_props

// file: test/testbench.sv
// self-checking bench for host and device ends of the frame link
`timescale 1ns/1ps
module testbench;
    import dac_frame_pkg::*;
    logic clk, rst_n, read, write, waitrequest;
    logic [3:0] address;
    logic [31:0] writedata, readdata, q;
    logic [NUM_CH-1:0][DATA_W-1:0] code_o, code2_o;
    logic [NUM_CH-1:0][RANGE_W-1:0] range_o;
    logic [NUM_CH-1:0] bip_o;
    logic [DATA_W-1:0] pwr_o, ctl_o;
    logic [15:0] exp_code [NUM_CH];
    logic [2:0] exp_range [NUM_CH];
    logic [15:0] exp_pwr, exp_ctl;
    int errors, tests_run;
    // frames with the register state they must leave, via apply()
    logic [23:0] rows [19] = '{24'h041111, 24'h00a5c3, 24'h01ffff,
        24'h020001, 24'h038000, 24'h08fff8, 24'h090001, 24'h0a0002,
        24'h0bfffb, 24'h080004, 24'h0c0005, 24'h090001, 24'h10beef,
        24'h19000f, 24'h20ffff, 24'h05dead, 24'h80ffff, 24'h020777,
        24'h15dead};

    dac_link_if link();
    dac_link_if link2();
    dac_frame_host u_dac_frame_host (.clk(clk), .rst_n(rst_n),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .link(link.host_end));
    dac_frame_device #(.RESOLUTION(16)) u_dac_frame_device (.clk(clk),
        .rst_n(rst_n), .link(link.device_end), .code_out_r(code_o),
        .range_out_r(range_o), .bipolar_out_r(bip_o),
        .power_word_r(pwr_o), .control_word_r(ctl_o), .frame_done_r());
    // second device faces the bench, which may break framing
    dac_frame_device #(.RESOLUTION(12)) u_dac_frame_device_12 (.clk(clk),
        .rst_n(rst_n), .link(link2.device_end), .code_out_r(code2_o),
        .range_out_r(), .bipolar_out_r(), .power_word_r(),
        .control_word_r(), .frame_done_r());
    dac_link_props u_dac_link_props (.clk(clk), .rst_n(rst_n),
        .sclk(link.sclk), .sync_n(link.sync_n),
        .serial_data_in(link.serial_data_in),
        .serial_data_out(link.serial_data_out));

    // 10 MHz system clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ****************************************************************
    // checking and reporting
    // ****************************************************************
    task automatic check(input logic [31:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic summarize();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // reference model of the register file
    function automatic void apply(input logic [23:0] f);
        if (f[23] == RW_WRITE && !f[21] && f[18:16] <= ADDR_ALL) begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (f[18:16] == ADDR_ALL || f[18:16] == 3'(c)) begin
                    if (f[21:19] == SEL_CODE) exp_code[c] = f[15:0];
                    if (f[21:19] == SEL_RANGE) exp_range[c] = f[2:0];
                end
            end
            if (f[21:19] == SEL_POWER) exp_pwr = f[15:0];
            if (f[21:19] == SEL_CONTROL) exp_ctl = f[15:0];
        end
    endfunction : apply

    function automatic void clear_model();
        foreach (exp_code[c]) exp_code[c] = CODE_RESET;
        foreach (exp_range[c]) exp_range[c] = RANGE_RESET;
        exp_pwr = WORD_RESET;
        exp_ctl = WORD_RESET;
    endfunction : clear_model

    task automatic check_all();
        for (int c = 0; c < NUM_CH; c++) begin
            check(32'(code_o[c]), 32'(exp_code[c]), "code");
            check(32'(range_o[c]), 32'(exp_range[c]), "range");
            check(32'(bip_o[c]), 32'(exp_range[c] >= 3'h3), "bip");
        end
        check(32'(pwr_o), 32'(exp_pwr), "power");
        check(32'(ctl_o), 32'(exp_ctl), "control");
    endtask : check_all

    // ****************************************************************
    // avalon master and frame helpers
    // ****************************************************************
    // request held until waitrequest is seen low at an edge
    task automatic av(input logic wr, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(negedge clk);
            n++;
            if (n > 500) begin
                errors++;
                summarize();
            end
        end while (waitrequest !== 1'b0);
        @(posedge clk);
        r = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask : av

    // frame through the host, then poll until done and idle
    task automatic send(input logic [23:0] f);
        int n;
        av(1'b1, OFS_CMD, {8'h00, f}, q);
        n = 0;
        do begin
            av(1'b0, OFS_STATUS, 32'h0, q);
            n++;
            if (n > 100) begin
                errors++;
                summarize();
            end
        end while (q[STAT_DONE] !== 1'b1 || q[STAT_BUSY] !== 1'b0);
        repeat (6) @(posedge clk);
        apply(f);
    endtask : send

    // bench-made frame of nb bits; sclk runs only inside it
    task automatic raw(input logic [23:0] f, input int nb);
        link2.sync_n <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            link2.serial_data_in <= f[23-i];
            link2.sclk <= 1'b1;
            repeat (4) @(posedge clk);
            link2.sclk <= 1'b0;
            repeat (4) @(posedge clk);
        end
        link2.sclk <= 1'b1;
        repeat (4) @(posedge clk);
        link2.sync_n <= 1'b1;
        link2.serial_data_in <= ~link2.serial_data_in;
        repeat (8) @(posedge clk);
    endtask : raw

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        errors = 0;
        tests_run = 0;
        rst_n = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        link2.sclk = 1'b1;
        link2.sync_n = 1'b1;
        link2.serial_data_in = 1'b0;
        clear_model();
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check_all();
        foreach (rows[i]) begin
            send(rows[i]);
            check_all();
        end
        // readback arrives in the frame after the read
        send(24'h810000);
        send(24'h180000);
        av(1'b0, OFS_RDATA, 32'h0, q);
        check(32'(q[23:0]), {8'h0, 8'h81, exp_code[1]}, "rb code");
        send(24'h8a0000);
        send(24'h180000);
        av(1'b0, OFS_RDATA, 32'h0, q);
        check(32'(q[23:0]), {16'h0081 + 16'h0009, 13'h0, exp_range[2]},
              "rb range");
        // narrow device drops low bits; short frame is discarded
        raw(24'h00abcd, 24);
        check(32'(code2_o[0]), 32'h0000abc0, "12-bit code");
        raw(24'h01ffff, 20);
        check(32'(code2_o[1]), 32'h0, "short frame");
        // reset in the middle of a frame
        av(1'b1, OFS_CMD, 32'h0003abcd, q);
        repeat (40) @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        clear_model();
        check_all();
        check(32'(link.sync_n), 32'h1, "sync idle");
        rst_n <= 1'b1;
        @(posedge clk);
        send(24'h030abc);
        check_all();
        summarize();
    end
endmodule : testbench

// file: verilog/dac_frame_device.sv
// device end: serial frame decoder and channel register file
//
// How it works
// R1: frames are exactly 24 bits, shifted in
// R2: bits arrive most significant first
// R3: frame fields: rw, zero, select, address, data
// R4: host drives bit 22 as zero
// R5: rw flag picks read or write
// R6: select 000 code, 001 range, 010/011 power/control
// R7: address 000..011 channels A-D, 100 all
// R8: select 000 writes data to code registers
// R9: code width 16/14/12, low bits ignored
// R10: select 001 stores range bits 2..0
// R11: range codes 0..5 map to six ranges
// R12: every register can be written and read back
// R13: act only after 24 bits and frame end
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module dac_frame_device
    import dac_frame_pkg::*;
#(
    parameter int RESOLUTION = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial link
    dac_link_if.device_end link,
    // channel state seen by the analogue side
    output logic [NUM_CH-1:0][DATA_W-1:0] code_out_r,
    output logic [NUM_CH-1:0][RANGE_W-1:0] range_out_r,
    output logic [NUM_CH-1:0] bipolar_out_r,
    output logic [DATA_W-1:0] power_word_r,
    output logic [DATA_W-1:0] control_word_r,
    // one-cycle pulse after each accepted frame whose address is 000..100
    output logic frame_done_r
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    localparam int UNUSED_LSB = DATA_W - RESOLUTION;
    localparam logic [DATA_W-1:0] CODE_MASK =
        {DATA_W{1'b1}} << UNUSED_LSB;

    initial begin
        if (RESOLUTION != 16 && RESOLUTION != 14 && RESOLUTION != 12) begin
            $error("resolution must be 16, 14 or 12");
        end
    end

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic sclk_s1, sclk_s2, sclk_s3;
    logic sync_s1, sync_s2, sync_s3;
    logic serial_data_in_s1, serial_data_in_s2;

    // all link pins cross from the host's timing into clk
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_s3 <= 1'b1;
            sync_s1 <= 1'b1;
            sync_s2 <= 1'b1;
            sync_s3 <= 1'b1;
            serial_data_in_s1 <= 1'b0;
            serial_data_in_s2 <= 1'b0;
        end else begin
            sclk_s1 <= link.sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            sync_s1 <= link.sync_n;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
            serial_data_in_s1 <= link.serial_data_in;
            serial_data_in_s2 <= serial_data_in_s1;
        end
    end

    // edge detection between the second and third stages
    logic sclk_fall, sclk_rise, frame_start, frame_end;
    assign sclk_fall = sclk_s3 & ~sclk_s2 & ~sync_s2;
    assign sclk_rise = ~sclk_s3 & sclk_s2 & ~sync_s2;
    assign frame_start = sync_s3 & ~sync_s2;
    assign frame_end = ~sync_s3 & sync_s2;

    // ****************************************************************
    // input shift register and bit counter
    // ****************************************************************
    logic [FRAME_BITS-1:0] shift_r;
    logic [CNT_W-1:0] bit_cnt_r;

    // sample on the falling serial clock, msb first
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= FRAME_RESET;
        end else if (sclk_fall) begin
            shift_r <= {shift_r[FRAME_BITS-2:0], serial_data_in_s2}; // R1 R2
        end
    end

    // counter saturates past 24 so an overlong frame is refused
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= '0;
        end else if (frame_start) begin
            bit_cnt_r <= '0;
        end else if (sclk_fall && bit_cnt_r <= FRAME_FULL) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
        end
    end

    // ****************************************************************
    // field decode
    // ****************************************************************
    logic f_rw;
    logic [2:0] f_sel;
    logic [2:0] f_addr;
    logic [DATA_W-1:0] f_data;
    logic accept;
    logic sel_ok, addr_ok;
    logic [NUM_CH-1:0] ch_hit;

    assign f_rw = shift_r[POS_RW]; // R3 R5
    assign f_sel = shift_r[POS_SEL_HI:POS_SEL_LO]; // R3
    assign f_addr = shift_r[POS_ADDR_HI:POS_ADDR_LO]; // R3
    assign f_data = shift_r[DATA_W-1:0]; // R3
    // the reserved bit is not checked; the host keeps it at zero
    assign sel_ok = (f_sel <= SEL_CONTROL); // R6 R13
    assign addr_ok = (f_addr <= ADDR_ALL); // R7 R13
    // only a complete frame, closed by sync, does anything
    assign accept = frame_end && (bit_cnt_r == FRAME_FULL) &&
                    sel_ok; // R13

    // channel enables, all four for the broadcast address
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_hit
            assign ch_hit[gi] = (f_addr == ADDR_ALL) ||
                                (f_addr == 3'(gi)); // R7
        end
    endgenerate

    logic do_write;
    assign do_write = accept && addr_ok && (f_rw == RW_WRITE); // R5 R13

    // ****************************************************************
    // channel registers
    // ****************************************************************
    generate
        for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_ch
            // code register, low bits cleared for narrow variants
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    code_out_r[gi] <= CODE_RESET;
                end else if (do_write && f_sel == SEL_CODE &&
                             addr_ok && ch_hit[gi]) begin
                    code_out_r[gi] <= f_data & CODE_MASK; // R8 R9
                end
            end

            // range register keeps only bits 2..0
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    range_out_r[gi] <= RANGE_RESET;
                end else if (do_write && f_sel == SEL_RANGE &&
                             addr_ok && ch_hit[gi]) begin
                    range_out_r[gi] <= f_data[RANGE_W-1:0]; // R10
                end
            end

            // polarity flag for the output stage
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    bipolar_out_r[gi] <= 1'b0;
                end else begin
                    case (range_out_r[gi])
                        RANGE_UNI_5V, RANGE_UNI_10V,
                        RANGE_UNI_10V8: bipolar_out_r[gi] <= 1'b0; // R11
                        RANGE_BI_5V, RANGE_BI_10V,
                        RANGE_BI_10V8: bipolar_out_r[gi] <= 1'b1; // R11
                        default: bipolar_out_r[gi] <= 1'b0;
                    endcase
                end
            end
        end
    endgenerate

    // power and control words are held whole; their fields live
    // in the analogue side, not here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_word_r <= WORD_RESET;
        end else if (do_write && f_sel == SEL_POWER) begin
            power_word_r <= f_data; // R6 R12
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_word_r <= WORD_RESET;
        end else if (do_write && f_sel == SEL_CONTROL) begin
            control_word_r <= f_data; // R6 R12
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_done_r <= 1'b0;
        end else begin
            frame_done_r <= accept && addr_ok;
        end
    end

    // ****************************************************************
    // readback
    // ****************************************************************
    logic [1:0] rd_ch;
    logic [DATA_W-1:0] rd_data;
    logic [FRAME_BITS-1:0] readback_r;
    logic [FRAME_BITS-1:0] tx_r;

    // broadcast address reads channel A
    assign rd_ch = (f_addr == ADDR_ALL) ? 2'h0 : f_addr[1:0];

    always_comb begin
        rd_data = WORD_RESET;
        case (f_sel)
            SEL_CODE: rd_data = code_out_r[rd_ch];
            SEL_RANGE: rd_data = {13'h0000, range_out_r[rd_ch]};
            SEL_POWER: rd_data = power_word_r;
            SEL_CONTROL: rd_data = control_word_r;
            default: rd_data = WORD_RESET;
        endcase
    end

    // a read frame prepares the word sent during the next frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            readback_r <= FRAME_RESET;
        end else if (accept && addr_ok && f_rw == RW_READ) begin
            readback_r <= {shift_r[FRAME_BITS-1:DATA_W], rd_data}; // R12
        end
    end

    // output shift: loaded at frame start, advanced per rising clock;
    // the host samples on that rise before this side has seen it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_r <= FRAME_RESET;
        end else if (frame_start) begin
            tx_r <= readback_r;
        end else if (sclk_rise) begin
            tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0}; // R2
        end
    end

    assign link.serial_data_out = tx_r[FRAME_BITS-1];

endmodule : dac_frame_device

// file: verilog/dac_frame_host.sv
// host end: avalon-mm command port driving the serial frame link
`timescale 1ns/1ps
module dac_frame_host
    import dac_frame_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // serial link
    dac_link_if.host_end link
);

    // ****************************************************************
    // parameter check
    // ****************************************************************
    // the device needs three clk cycles to see each link edge
    initial begin
        if (HALF_CYC < SCLK_HALF_MIN || HALF_CYC > 255) begin
            $error("serial clock half period out of range");
        end
    end

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SHIFT = 3'b010,
        ST_END = 3'b100
    } host_state_t;

    host_state_t state_r;
    logic [7:0] div_r;
    logic div_wrap;
    logic [CNT_W-1:0] bit_r;
    logic [FRAME_BITS-1:0] tx_r, rx_r, rdata_r;
    logic sclk_r, sync_n_r, serial_data_in_r, done_r;
    logic sdo_s1, sdo_s2;
    logic wait_r;
    logic [31:0] rd_r;
    logic start;

    assign div_wrap = (div_r == 8'(HALF_CYC - 1));

    // ****************************************************************
    // avalon slave: answer one cycle after the request appears
    // ****************************************************************
    // a command write stalls while a frame is still running
    assign start = write && !wait_r && address == OFS_CMD;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_r <= 1'b1;
        end else if (!wait_r) begin
            wait_r <= 1'b1;
        end else if (read || (write && (address != OFS_CMD ||
                     state_r == ST_IDLE))) begin
            wait_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_r <= 32'h00000000;
        end else if (read && wait_r) begin
            case (address)
                OFS_CMD: rd_r <= {8'h00, tx_r};
                OFS_STATUS: rd_r <= {30'h00000000, done_r,
                                     state_r != ST_IDLE};
                OFS_RDATA: rd_r <= {8'h00, rdata_r};
                default: rd_r <= 32'h00000000;
            endcase
        end
    end

    assign readdata = rd_r;
    assign waitrequest = wait_r;

    // ****************************************************************
    // frame engine
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_s1 <= 1'b0;
            sdo_s2 <= 1'b0;
        end else begin
            sdo_s1 <= link.serial_data_out;
            sdo_s2 <= sdo_s1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 8'h00;
        end else if (state_r == ST_IDLE || div_wrap) begin
            div_r <= 8'h00;
        end else begin
            div_r <= div_r + 8'h01;
        end
    end

    // clock idles high; device samples on the falling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            sclk_r <= 1'b1;
            sync_n_r <= 1'b1;
            serial_data_in_r <= 1'b0;
            bit_r <= '0;
            tx_r <= FRAME_RESET;
            rx_r <= FRAME_RESET;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        // reserved bit forced low whatever software wrote
                        tx_r <= {writedata[POS_RW], 1'b0,
                                 writedata[POS_ZERO-1:0]}; // R1 R4
                        serial_data_in_r <= writedata[FRAME_BITS-1]; // R2
                        sync_n_r <= 1'b0;
                        bit_r <= '0;
                        state_r <= ST_SHIFT;
                    end
                end
                ST_SHIFT: begin
                    if (div_wrap && sclk_r) begin
                        sclk_r <= 1'b0;
                    end else if (div_wrap) begin
                        // device shifts on the rise it has not yet seen
                        rx_r <= {rx_r[FRAME_BITS-2:0], sdo_s2};
                        sclk_r <= 1'b1;
                        bit_r <= bit_r + 5'h01;
                        tx_r <= {tx_r[FRAME_BITS-2:0], 1'b0};
                        serial_data_in_r <= tx_r[FRAME_BITS-2]; // R2
                        if (bit_r == FRAME_LAST) begin
                            state_r <= ST_END; // R1
                        end
                    end
                end
                ST_END: begin
                    if (div_wrap) begin
                        sync_n_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // received word and sticky done flag (a new start clears it)
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= FRAME_RESET;
            done_r <= 1'b0;
        end else if (state_r == ST_END && div_wrap) begin
            rdata_r <= rx_r;
            done_r <= 1'b1;
        end else if (start) begin
            done_r <= 1'b0;
        end
    end

    assign link.sclk = sclk_r;
    assign link.sync_n = sync_n_r;
    assign link.serial_data_in = serial_data_in_r;

endmodule : dac_frame_host

// file: verilog/dac_frame_pkg.sv
// shared constants for the quad converter serial frame link
package dac_frame_pkg;

    // ****************************************************************
    // frame layout
    // ****************************************************************
    localparam int FRAME_BITS = 24;
    localparam int CNT_W = 5;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] FRAME_FULL = 5'h18;
    localparam int POS_RW = 23;
    localparam int POS_ZERO = 22;
    localparam int POS_SEL_HI = 21;
    localparam int POS_SEL_LO = 19;
    localparam int POS_ADDR_HI = 18;
    localparam int POS_ADDR_LO = 16;
    localparam int DATA_W = 16;
    localparam int RANGE_W = 3;
    localparam int NUM_CH = 4;

    // ****************************************************************
    // register select and channel address codes
    // ****************************************************************
    localparam logic [2:0] SEL_CODE = 3'h0;
    localparam logic [2:0] SEL_RANGE = 3'h1;
    localparam logic [2:0] SEL_POWER = 3'h2;
    localparam logic [2:0] SEL_CONTROL = 3'h3;
    localparam logic [2:0] ADDR_ALL = 3'h4;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;

    // ****************************************************************
    // output range codes
    // ****************************************************************
    localparam logic [2:0] RANGE_UNI_5V = 3'h0;
    localparam logic [2:0] RANGE_UNI_10V = 3'h1;
    localparam logic [2:0] RANGE_UNI_10V8 = 3'h2;
    localparam logic [2:0] RANGE_BI_5V = 3'h3;
    localparam logic [2:0] RANGE_BI_10V = 3'h4;
    localparam logic [2:0] RANGE_BI_10V8 = 3'h5;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [15:0] CODE_RESET = 16'h0000;
    localparam logic [2:0] RANGE_RESET = 3'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [23:0] FRAME_RESET = 24'h000000;

    // ****************************************************************
    // host register map (byte addresses) and timing
    // ****************************************************************
    localparam logic [3:0] OFS_CMD = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RDATA = 4'h8;
    localparam int STAT_BUSY = 0;
    localparam int STAT_DONE = 1;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_PERIOD_NS = 800;
    localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam int SCLK_HALF_MIN = 4;

endpackage : dac_frame_pkg

// file: verilog/dac_link_if.sv
// serial frame link between host controller and converter device
`timescale 1ns/1ps
interface dac_link_if;
    logic sclk;
    logic sync_n;
    logic serial_data_in;
    logic serial_data_out;

    modport host_end (
        output sclk,
        output sync_n,
        output serial_data_in,
        input serial_data_out
    );

    modport device_end (
        input sclk,
        input sync_n,
        input serial_data_in,
        output serial_data_out
    );
endinterface : dac_link_if
